// >>> hdl/timer2_cfg.svh
`ifndef TIMER2_CFG_SVH
`define TIMER2_CFG_SVH

// ==========================================================
// Register offsets
`define ADR_IEN_FIRST   8'ha8
`define ADR_IEN_SECOND  8'hb8
`define ADR_IRQ_FLAGS   8'hc0
`define ADR_CC_ENABLE   8'hc1
`define ADR_CC1_LOW     8'hc2
`define ADR_CC1_HIGH    8'hc3
`define ADR_CC2_LOW     8'hc4
`define ADR_CC2_HIGH    8'hc5
`define ADR_CC3_LOW     8'hc6
`define ADR_CC3_HIGH    8'hc7
`define ADR_T2_CONTROL  8'hc8
`define ADR_RCC_LOW     8'hca
`define ADR_RCC_HIGH    8'hcb
`define ADR_COUNT_LOW   8'hcc
`define ADR_COUNT_HIGH  8'hcd

// ==========================================================
// Field positions and reset values
`define SECOND_TIMER_CONTROL_RESET     8'h00
`define IEN_FIRST_T2IE  5
`define IEN_SECOND_EXEN 7
`define IRQ_FLAG_OVF    6
`define IRQ_FLAG_EXT    7

// ==========================================================
// Prescaler divide ratios in oscillator periods
`define DIV_FAST        5'd12
`define DIV_SLOW        5'd24

`endif

// >>> hdl/timer2_pkg.sv
package timer2_pkg;

  typedef enum logic [1:0] {
    IN_STOP    = 2'b00,
    IN_TIMER   = 2'b01,
    IN_COUNTER = 2'b10,
    IN_GATED   = 2'b11
  } input_sel_t;

  typedef struct packed {
    logic       prescale_select;
    logic       capture_edge_select;
    logic       unused_edge_bit;
    logic       reload_mode_upper;
    logic       reload_mode_lower;
    logic       compare_mode_select;
    input_sel_t input_select;
  } t2_control_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [4:0] cnt;
  } presc_state_t;

  typedef struct packed {
    logic [3:0] pin_last;
  } edge_state_t;

  typedef struct packed {
    t2_control_t      ctl;
    logic [7:0]       ien_first;
    logic [7:0]       ien_second;
    logic [7:0]       irq_flags;
    logic [7:0]       cc_enable;
    logic [2:0][15:0] cc;
    logic [15:0]      rcc;
    logic [15:0]      count;
    logic             gate_last;
    logic             trig_last;
    logic [7:0]       rdata;
  } t2_state_t;

endpackage

// >>> hdl/timer2_prescaler.sv
`timescale 1ns/1ps
`include "timer2_cfg.svh"

module timer2_prescaler
  import timer2_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Control
  input  wire logic slow_i,
  // Count enable pulse
  output logic      tick_o
);

  presc_state_t s_q;
  presc_state_t s_d;
  logic [4:0]   limit;

  always_comb begin
    s_d   = s_q;
    limit = slow_i ? `DIV_SLOW : `DIV_FAST;
    // A ratio change mid-period finishes within the longer ratio
    if (s_q.cnt >= limit - 5'd1) begin
      s_d.cnt = 5'd0;
    end else begin
      s_d.cnt = s_q.cnt + 5'd1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = (s_q.cnt >= limit - 5'd1);

endmodule // timer2_prescaler

// >>> hdl/timer2_capture_edges.sv
`timescale 1ns/1ps

module timer2_capture_edges
  import timer2_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Capture pins
  input  wire logic [3:0] pin_i,
  // Edge pulses
  output logic      [3:0] rise_o,
  output logic      [3:0] fall_o
);

  edge_state_t s_q;
  edge_state_t s_d;

  always_comb begin
    s_d          = s_q;
    s_d.pin_last = pin_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_edge
    assign rise_o[i] = pin_i[i] & ~s_q.pin_last[i];
    assign fall_o[i] = ~pin_i[i] & s_q.pin_last[i];
  end

endmodule // timer2_capture_edges

// >>> hdl/timer2_control_config.sv
`timescale 1ns/1ps
`include "timer2_cfg.svh"

module timer2_control_config
  import timer2_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Pins
  input  wire logic       count_gate_pin_i,
  input  wire logic       reload_trigger_pin_i,
  input  wire logic [3:0] capture_pin_i,
  // Status
  output logic            compare_mode_o,
  output logic [15:0]     count_o,
  output logic            irq_o
);

  // ==========================================================
  // State
  t2_state_t  s_q;
  t2_state_t  s_d;
  reg_req_t   req;
  logic       tick;
  logic [3:0] cap_rise;
  logic [3:0] cap_fall;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  timer2_prescaler u_presc (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .slow_i    (s_q.ctl.prescale_select),
    .tick_o    (tick)
  );

  timer2_capture_edges u_edges (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     (capture_pin_i),
    .rise_o    (cap_rise),
    .fall_o    (cap_fall)
  );

  // ==========================================================
  // Next state
  logic        advance;
  logic        overflow;
  logic        reload;
  logic        trig_fall;
  logic        gate_fall;
  logic        rcc_cap;
  logic [15:0] cnt_next;

  always_comb begin
    s_d          = s_q;
    s_d.gate_last = count_gate_pin_i;
    s_d.trig_last = reload_trigger_pin_i;
    gate_fall    = s_q.gate_last & ~count_gate_pin_i;
    trig_fall    = s_q.trig_last & ~reload_trigger_pin_i;

    case (s_q.ctl.input_select)
      IN_STOP:    advance = 1'b0;
      IN_TIMER:   advance = tick;
      IN_COUNTER: advance = gate_fall;
      IN_GATED:   advance = tick & count_gate_pin_i;
      default:    advance = 1'b0;
    endcase

    overflow = advance & (s_q.count == 16'hffff);
    cnt_next = s_q.count + 16'h0001;
    reload   = 1'b0;
    if (s_q.ctl.reload_mode_upper) begin
      if (s_q.ctl.reload_mode_lower) begin
        reload = trig_fall;
      end else begin
        reload = overflow;
      end
    end

    if (reload) begin
      s_d.count = s_q.rcc;
    end else if (advance) begin
      s_d.count = cnt_next;
    end

    // Software write to the count bytes wins over counting that cycle
    if (req.wr && req.addr == `ADR_COUNT_LOW) begin
      s_d.count[7:0] = req.wdata;
    end
    if (req.wr && req.addr == `ADR_COUNT_HIGH) begin
      s_d.count[15:8] = req.wdata;
    end

    // Plain register writes
    if (req.wr) begin
      case (req.addr)
        `ADR_T2_CONTROL: s_d.ctl        = t2_control_t'(req.wdata);
        `ADR_IEN_FIRST:  s_d.ien_first  = req.wdata;
        `ADR_IEN_SECOND: s_d.ien_second = req.wdata;
        `ADR_IRQ_FLAGS:  s_d.irq_flags  = req.wdata;
        `ADR_CC_ENABLE:  s_d.cc_enable  = req.wdata;
        `ADR_RCC_LOW:    s_d.rcc[7:0]   = req.wdata;
        `ADR_RCC_HIGH:   s_d.rcc[15:8]  = req.wdata;
        `ADR_CC1_LOW:    s_d.cc[0][7:0]  = req.wdata;
        `ADR_CC1_HIGH:   s_d.cc[0][15:8] = req.wdata;
        `ADR_CC2_LOW:    s_d.cc[1][7:0]  = req.wdata;
        `ADR_CC2_HIGH:   s_d.cc[1][15:8] = req.wdata;
        `ADR_CC3_LOW:    s_d.cc[2][7:0]  = req.wdata;
        `ADR_CC3_HIGH:   s_d.cc[2][15:8] = req.wdata;
        default:         s_d.ien_first  = s_d.ien_first;
      endcase
    end

    // Capture into the reload register: pin edge or write to its low byte
    rcc_cap = 1'b0;
    if (s_q.cc_enable[1:0] == 2'b01) begin
      rcc_cap = s_q.ctl.capture_edge_select ? cap_rise[0] : cap_fall[0];
    end else if (s_q.cc_enable[1:0] == 2'b11) begin
      rcc_cap = req.wr && (req.addr == `ADR_RCC_LOW);
    end
    if (rcc_cap) begin
      s_d.rcc = s_q.count;
    end

    // Remaining channels capture on rising edges or low-byte writes
    for (int i = 0; i < 3; i++) begin
      if ((s_q.cc_enable[2*i+2 +: 2] == 2'b01 && cap_rise[i+1]) ||
          (s_q.cc_enable[2*i+2 +: 2] == 2'b11 && req.wr &&
           req.addr == `ADR_CC1_LOW + 8'(2*i))) begin
        s_d.cc[i] = s_q.count;
      end
    end

    // Hardware sets win over a software clear in the same cycle
    if (overflow) begin
      s_d.irq_flags[`IRQ_FLAG_OVF] = 1'b1;
    end
    if (reload && s_q.ctl.reload_mode_lower && s_q.ien_second[`IEN_SECOND_EXEN]) begin
      s_d.irq_flags[`IRQ_FLAG_EXT] = 1'b1;
    end

    // Read data stand only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `ADR_T2_CONTROL: s_d.rdata = s_q.ctl;
        `ADR_IEN_FIRST:  s_d.rdata = s_q.ien_first;
        `ADR_IEN_SECOND: s_d.rdata = s_q.ien_second;
        `ADR_IRQ_FLAGS:  s_d.rdata = s_q.irq_flags;
        `ADR_CC_ENABLE:  s_d.rdata = s_q.cc_enable;
        `ADR_RCC_LOW:    s_d.rdata = s_q.rcc[7:0];
        `ADR_RCC_HIGH:   s_d.rdata = s_q.rcc[15:8];
        `ADR_CC1_LOW:    s_d.rdata = s_q.cc[0][7:0];
        `ADR_CC1_HIGH:   s_d.rdata = s_q.cc[0][15:8];
        `ADR_CC2_LOW:    s_d.rdata = s_q.cc[1][7:0];
        `ADR_CC2_HIGH:   s_d.rdata = s_q.cc[1][15:8];
        `ADR_CC3_LOW:    s_d.rdata = s_q.cc[2][7:0];
        `ADR_CC3_HIGH:   s_d.rdata = s_q.cc[2][15:8];
        `ADR_COUNT_LOW:  s_d.rdata = s_q.count[7:0];
        `ADR_COUNT_HIGH: s_d.rdata = s_q.count[15:8];
        default:         s_d.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q     <= '0;
      s_q.ctl <= t2_control_t'(`SECOND_TIMER_CONTROL_RESET);
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_o        = s_q.rdata;
  assign compare_mode_o = s_q.ctl.compare_mode_select;
  assign count_o        = s_q.count;
  assign irq_o          = s_q.ien_first[`IEN_FIRST_T2IE] &
                          (s_q.irq_flags[`IRQ_FLAG_OVF] | s_q.irq_flags[`IRQ_FLAG_EXT]);

endmodule // timer2_control_config

// >>> dv/timer2_control_config_asserts.sv
`timescale 1ns/1ps

module timer2_control_config_asserts (
  // Clock, reset, register port
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // Pins and status
  input wire logic        count_gate_pin_i,
  input wire logic        reload_trigger_pin_i,
  input wire logic [3:0]  capture_pin_i,
  input wire logic        compare_mode_o,
  input wire logic [15:0] count_o,
  input wire logic        irq_o
);
  // ==========================================================
  // Shadows of what software wrote, plus last-cycle pin samples; hardware never alters these
  logic [7:0] ctl_q, ie1_q, ie2_q;
  logic       gate_q, trig_q, fall_w, tfall_w;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctl_q  <= 8'h00;
      ie1_q  <= 8'h00;
      ie2_q  <= 8'h00;
      gate_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      if (wr_i && addr_i == 8'hc8) ctl_q <= wdata_i;
      if (wr_i && addr_i == 8'ha8) ie1_q <= wdata_i;
      if (wr_i && addr_i == 8'hb8) ie2_q <= wdata_i;
      gate_q <= count_gate_pin_i;
      trig_q <= reload_trigger_pin_i;
    end
  end
  assign fall_w  = gate_q & ~count_gate_pin_i;
  assign tfall_w = trig_q & ~reload_trigger_pin_i;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Properties
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=> count_o == 16'h0 && !compare_mode_o && !irq_o)
    else $error("state not cleared by reset");
  mode_out_a: assert property (wr_i && addr_i == 8'hc8 |=> compare_mode_o == $past(wdata_i[2]))
    else $error("compare mode output wrong");
  stop_hold_a: assert property (ctl_q[1:0] == 2'b00 && ctl_q[4:3] != 2'b11 && !wr_i |=> $stable(count_o))
    else $error("stopped timer moved");
  event_cnt_a: assert property (ctl_q[1:0] == 2'b10 && ctl_q[4:3] == 2'b00 && !wr_i
    |=> count_o == $past(count_o) + {15'h0, $past(fall_w)}) else $error("event count wrong");
  gate_hold_a: assert property ((ctl_q[1:0] == 2'b11 && ctl_q[4:3] != 2'b11 && !count_gate_pin_i && !wr_i)[*2]
    |=> $stable(count_o)) else $error("gated timer moved with gate low");
  ext_flag_a: assert property (ctl_q[4:3] == 2'b11 && tfall_w && ie2_q[7] && ie1_q[5] && !wr_i |=> irq_o)
    else $error("reload flag not raised");
  ovf_flag_a: assert property (ie1_q[5] && ctl_q[4:3] != 2'b11 && count_o == 16'hffff && !wr_i
    ##1 count_o != 16'hffff |-> irq_o) else $error("overflow flag not raised");
  irq_mask_a: assert property (!ie1_q[5] |-> !irq_o)
    else $error("interrupt while disabled");

  cover property (ctl_q[4:3] == 2'b11 && tfall_w);
  cover property (ctl_q[1:0] == 2'b10 && fall_w);
  cover property (irq_o);
endmodule // timer2_control_config_asserts

bind timer2_control_config timer2_control_config_asserts chk_u (.clk_sys_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .count_gate_pin_i, .reload_trigger_pin_i, .capture_pin_i, .compare_mode_o, .count_o, .irq_o);

// >>> dv/timer2_pins.sv
`timescale 1ns/1ps

module timer2_pins (
  // Clock
  input  wire logic       clk_sys_i,
  // Pins toward the timer
  output logic            gate_o,
  output logic            trig_o,
  output logic      [3:0] cap_o
);
  // Pins move just after an edge, as a synchronised board signal would
  initial begin
    gate_o = 1'b0;
    trig_o = 1'b0;
    cap_o  = 4'h0;
  end
  task automatic drive(input logic g, input logic t, input logic [3:0] c);
    @(posedge clk_sys_i);
    gate_o <= g;
    trig_o <= t;
    cap_o  <= c;
  endtask
endmodule // timer2_pins

// >>> dv/tb_timer2_control_config.sv
`timescale 1ns/1ps

module tb_timer2_control_config;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, gate, trig, cmode, irq;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v;
  logic [3:0]  cap;
  logic [15:0] count, x, rl;
  int          seed = 32'h5630, fail_count = 0, compares = 0, cyc_n = 0, k, n;

  always #25 clk = ~clk;

  timer2_control_config dut_u (.clk_sys_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .count_gate_pin_i(gate), .reload_trigger_pin_i(trig), .capture_pin_i(cap),
    .compare_mode_o(cmode), .count_o(count), .irq_o(irq));
  timer2_pins pins_u (.clk_sys_i(clk), .gate_o(gate), .trig_o(trig), .cap_o(cap));

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, {8'h0, rdata}, {8'h0, e});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Bounded wait; k ends as the edge count to the change
  task automatic wait_chg;
    x = count;
    k = 0;
    while (count === x && k < 200) begin
      cyc(1);
      k++;
    end
  endtask
  // First change after a mode switch may be short, so time the second
  task automatic gap(input logic [7:0] c, input int e);
    w(8'hc8, c);
    wait_chg();
    wait_chg();
    chk("tick gap", 16'(k), 16'(e));
  endtask
  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    r(8'hc8, 8'h00, "control reset");
    r(8'hc9, 8'h00, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      if (v[1:0] == 2'b10) begin
        v[7] = 1'b0;
      end
      w(8'hc8, v);
      r(8'hc8, v, "control");
      chk("compare mode", {15'h0, cmode}, {15'h0, v[2]});
    end
    gap(8'h01, 12);
    gap(8'h81, 24);
    w(8'hc8, 8'h02);
    cyc(1);
    rl = count;
    n = 1 + ($random(seed) & 7);
    repeat (n) begin
      pins_u.drive(1'b1, 1'b0, 4'h0);
      pins_u.drive(1'b0, 1'b0, 4'h0);
    end
    cyc(2);
    chk("event count", count, rl + 16'(n));
    w(8'hc8, 8'h03);
    cyc(2);
    rl = count;
    cyc(50);
    chk("gate low", count, rl);
    pins_u.drive(1'b1, 1'b0, 4'h0);
    cyc(47);
    pins_u.drive(1'b0, 1'b0, 4'h0);
    cyc(3);
    chk("gated count", count, rl + 16'h4);
    w(8'hc8, 8'h00);
    w(8'hc1, 8'h01);
    x = 16'($random(seed));
    w(8'hcc, x[7:0]);
    w(8'hcd, x[15:8]);
    for (int e = 0; e < 2; e++) begin
      w(8'hca, ~x[7:0]);
      w(8'hcb, ~x[15:8]);
      w(8'hc8, e ? 8'h40 : 8'h00);
      pins_u.drive(1'b0, 1'b0, 4'h1);
      cyc(2);
      r(8'hca, e ? x[7:0] : ~x[7:0], "capture rise");
      pins_u.drive(1'b0, 1'b0, 4'h0);
      cyc(2);
      r(8'hcb, x[15:8], "capture fall");
    end
    // Channel one captures the stopped count on a rising edge of its pin
    w(8'hc1, 8'h04);
    pins_u.drive(1'b0, 1'b0, 4'h2);
    cyc(2);
    r(8'hc2, x[7:0], "channel one capture");
    pins_u.drive(1'b0, 1'b0, 4'h0);
    w(8'hc1, 8'h00);
    // Keep the reload value clear of the top of the range, so the wait loop ends
    rl = (16'($random(seed)) | 16'h0100) & 16'h7fff;
    w(8'hca, rl[7:0]);
    w(8'hcb, rl[15:8]);
    w(8'ha8, 8'h20);
    for (int u = 0; u < 2; u++) begin
      w(8'hcc, 8'hfe);
      w(8'hcd, 8'hff);
      w(8'hc8, u ? 8'h11 : 8'h01);
      k = 0;
      while (count >= 16'hfffe && k < 100) begin
        cyc(1);
        k++;
      end
      chk("overflow value", count, u ? rl : 16'h0);
      chk("overflow irq", {15'h0, irq}, 16'h1);
      w(8'hc8, 8'h00);
      r(8'hc0, 8'h40, "overflow flag");
      w(8'hc0, 8'h00);
      cyc(1);
      chk("irq cleared", {15'h0, irq}, 16'h0);
    end
    w(8'hcc, 8'h00);
    w(8'hcd, 8'h00);
    w(8'hb8, 8'h80);
    w(8'hc8, 8'h18);
    pins_u.drive(1'b0, 1'b1, 4'h0);
    pins_u.drive(1'b0, 1'b0, 4'h0);
    cyc(2);
    chk("trigger reload", count, rl);
    chk("reload irq", {15'h0, irq}, 16'h1);
    r(8'hc0, 8'h80, "reload flag");
    give_verdict();
  end
endmodule // tb_timer2_control_config
